/* shared/dial_pkg.sv */
// constants shared by the dial command parser and its pacing timer
// assumes a single 40 mhz clock and 8-bit command characters
package dial_pkg;
   localparam int          CLK_HZ         = 40_000_000;
   localparam int          QUARTER_MS     = 250;          // pacing step in ms
   localparam int          LED_ON_MS      = 750;          // indicator on time per second
   localparam int          DIV_W          = 24;
   localparam logic [23:0] QUARTER_CYCLES = 24'(CLK_HZ / 1000 * QUARTER_MS);
   localparam logic [1:0]  ON_QUARTERS    = 2'(LED_ON_MS / QUARTER_MS);
   localparam int          SYNC_W         = 4;
   localparam int          SY_EXCH        = 0;            // exchange link lost
   localparam int          SY_PHONE       = 1;            // telephone link lost
   localparam int          SY_CLEAR       = 2;            // telephone cleared voice call
   localparam int          SY_HOLD        = 3;            // voice call placed on hold
   localparam logic [3:0]  SYNC_RST       = 4'h0;
   localparam logic [7:0]  CH_D           = 8'h44;
   localparam logic [7:0]  CH_P           = 8'h50;
   localparam logic [7:0]  CH_T           = 8'h54;
   localparam logic [7:0]  CH_H           = 8'h48;
   localparam logic [7:0]  CH_O           = 8'h4f;
   localparam logic [7:0]  CH_COMMA       = 8'h2c;
   localparam logic [7:0]  CH_SEMI        = 8'h3b;
   localparam logic [7:0]  CH_PLUS        = 8'h2b;
   localparam logic [7:0]  CH_CR          = 8'h0d;
   localparam logic [7:0]  CH_SPACE       = 8'h20;
   localparam logic [7:0]  CH_HYPHEN      = 8'h2d;
   localparam logic [7:0]  CH_STAR        = 8'h2a;
   localparam logic [7:0]  CH_HASH        = 8'h23;
   localparam logic [7:0]  CH_ZERO        = 8'h30;
   localparam logic [7:0]  CH_NINE        = 8'h39;
   localparam logic [1:0]  PLUS_LAST      = 2'h2;
   typedef enum logic [2:0] {ST_CMD, ST_DIAL, ST_SKIP, ST_DATA} parse_state_e;
endpackage

/* shared/pace_if.sv */
// pacing link between the parser and the seconds timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pace_if;
   logic       start;   // one-cycle request to load a delay
   logic [7:0] secs;    // delay length in seconds
   logic       busy;    // delay running
   logic [1:0] phase;   // quarter of the free-running second
   modport ctrl  (output start, output secs, input busy, input phase);
   modport timer (input start, input secs, output busy, output phase);
endinterface

/* src/pace_timer.sv */
// free-running quarter-second phase and restartable seconds delay
// assumes start is a one-cycle pulse from the parser on the same clock
`timescale 1ns/1ps
module pace_timer #(
   parameter logic [23:0] QUARTER_CYCLES = dial_pkg::QUARTER_CYCLES
) (
   input  wire logic ref_clk,           // system clock
   input  wire logic rst_n,             // synchronous reset, active low
   pace_if.timer     pace               // pacing link
);
   logic [dial_pkg::DIV_W-1:0] fdiv_reg, fdiv_next, ddiv_reg, ddiv_next;
   logic [1:0]                 phase_reg, phase_next;
   logic [9:0]                 quarters_reg, quarters_next;
   logic                       ftick;

   // free divider and delay countdown
   always_comb begin
      ftick         = (fdiv_reg == QUARTER_CYCLES - 24'h000001);
      fdiv_next     = ftick ? '0 : fdiv_reg + 24'h000001;
      phase_next    = ftick ? phase_reg + 2'h1 : phase_reg;
      ddiv_next     = ddiv_reg;
      quarters_next = quarters_reg;
      if (pace.start) begin
         quarters_next = {pace.secs, 2'b00};
         ddiv_next     = '0;
      end else if (quarters_reg != 10'h000) begin
         if (ddiv_reg == QUARTER_CYCLES - 24'h000001) begin
            ddiv_next     = '0;
            quarters_next = quarters_reg - 10'h001;
         end else begin
            ddiv_next = ddiv_reg + 24'h000001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fdiv_reg     <= '0;
         phase_reg    <= 2'h0;
         ddiv_reg     <= '0;
         quarters_reg <= 10'h000;
      end else begin
         fdiv_reg     <= fdiv_next;
         phase_reg    <= phase_next;
         ddiv_reg     <= ddiv_next;
         quarters_reg <= quarters_next;
      end
   end

   assign pace.busy  = (quarters_reg != 10'h000);
   assign pace.phase = phase_reg;

   // phase only moves on the free divider tick
   AST_PHASE_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(phase_reg) |-> $past(ftick))
      else $error("phase moved without divider tick");
   // a delay loads four quarters per second
   AST_DELAY_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pace.start |=> quarters_reg == {$past(pace.secs), 2'b00})
      else $error("delay loaded wrong length");
endmodule

/* src/voice_dial_command_parser.sv */
// dial command line parser with voice/data dialing, pauses and link indicators
// assumes command characters arrive from same-clock logic with valid/ready,
// and that the link and telephone status pins are asynchronous
`timescale 1ns/1ps
module voice_dial_command_parser #(
   parameter logic [23:0] QUARTER_CYCLES = dial_pkg::QUARTER_CYCLES
) (
   input  wire logic       ref_clk,            // system clock
   input  wire logic       rst_n,              // synchronous reset, active low
   input  wire logic       rx_valid,           // command character offered
   input  wire logic [7:0] rx_char,            // command character
   output logic            rx_ready,           // character taken this cycle
   input  wire logic [7:0] blind_dial_wait,    // seconds before first voice digit
   input  wire logic [7:0] comma_pause_length, // seconds per comma
   input  wire logic       silence_replies,    // suppress result codes
   input  wire logic       spk_inhibit,        // never switch speakerphone on
   input  wire logic       spk_after_dial,     // speakerphone on only after dialing
   input  wire logic       exch_lost_pin,      // exchange link lost, async
   input  wire logic       phone_lost_pin,     // telephone link lost, async
   input  wire logic       phone_clear_pin,    // telephone cleared voice call, async
   input  wire logic       call_hold_pin,      // voice call on hold, async
   output logic            dial_digit_valid,   // one-cycle digit strobe
   output logic [7:0]      dial_digit,         // digit character
   output logic            dial_pulse,         // digit uses pulse dialing
   output logic            result_ok,          // one-cycle ok result
   output logic            result_connect,     // one-cycle connect result
   output logic            data_mode,          // in data mode
   output logic            data_call,          // data call up
   output logic            voice_call,         // voice call up
   output logic            speaker_on,         // speakerphone control
   output logic            led_green,          // green indicator
   output logic            led_red             // red indicator
);
   pace_if pace ();

   pace_timer #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_pace (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pace    (pace)
   );

   // digits and tone keys that are sent, anything else is skipped
   function automatic logic is_dial_digit(input logic [7:0] c);
      return (c >= dial_pkg::CH_ZERO && c <= dial_pkg::CH_NINE) ||
             c == dial_pkg::CH_STAR || c == dial_pkg::CH_HASH;
   endfunction

   dial_pkg::parse_state_e state_reg, state_next;
   logic [3:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
   logic       voice_reg, voice_next, waited_reg, waited_next, vline_reg, vline_next;
   logic       vcall_reg, vcall_next, dcall_reg, dcall_next;
   logic [1:0] plus_reg, plus_next;
   logic       ok_reg, ok_next, conn_reg, conn_next, dv_reg, dv_next, pulse_reg, pulse_next;
   logic [7:0] digit_reg, digit_next;
   logic       spk_reg, spk_next, green_reg, green_next, red_reg, red_next;
   logic       take, hold_digit, blink;

   // status pins pass three flops; a change counts once stages two and three agree
   always_comb begin
      filt_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_reg   <= dial_pkg::SYNC_RST;
         s2_reg   <= dial_pkg::SYNC_RST;
         s3_reg   <= dial_pkg::SYNC_RST;
         filt_reg <= dial_pkg::SYNC_RST;
      end else begin
         s1_reg   <= {call_hold_pin, phone_clear_pin, phone_lost_pin, exch_lost_pin};
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   // command parser
   always_comb begin
      state_next  = state_reg;
      voice_next  = voice_reg;
      waited_next = waited_reg;
      vline_next  = vline_reg;
      vcall_next  = vcall_reg;
      dcall_next  = dcall_reg;
      plus_next   = plus_reg;
      ok_next     = 1'b0;
      conn_next   = 1'b0;
      dv_next     = 1'b0;
      pulse_next  = pulse_reg;
      digit_next  = digit_reg;
      rx_ready    = 1'b0;
      pace.start  = 1'b0;
      pace.secs   = comma_pause_length;
      hold_digit  = 1'b0;
      if (filt_reg[dial_pkg::SY_CLEAR])
         vcall_next = 1'b0;
      case (state_reg)
         dial_pkg::ST_CMD: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               case (rx_char)
                  dial_pkg::CH_D: begin
                     voice_next  = 1'b0;
                     waited_next = 1'b0;
                     state_next  = vline_reg ? dial_pkg::ST_SKIP : dial_pkg::ST_DIAL;
                  end
                  dial_pkg::CH_H: begin
                     dcall_next = 1'b0;
                     ok_next    = !silence_replies;
                  end
                  dial_pkg::CH_O: begin
                     if (dcall_reg) begin
                        state_next = dial_pkg::ST_DATA;
                        conn_next  = !silence_replies;
                     end
                  end
                  dial_pkg::CH_CR: vline_next = 1'b0;
                  default: ;
               endcase
            end
         end
         dial_pkg::ST_DIAL: begin
            hold_digit = rx_valid && voice_reg && !waited_reg && is_dial_digit(rx_char);
            rx_ready   = !pace.busy && !hold_digit;
            if (hold_digit && !pace.busy) begin
               pace.start  = 1'b1;
               pace.secs   = blind_dial_wait;
               waited_next = 1'b1;
            end
            if (rx_valid && rx_ready) begin
               case (rx_char)
                  dial_pkg::CH_P: begin
                     if (vcall_reg && !filt_reg[dial_pkg::SY_HOLD])
                        state_next = dial_pkg::ST_SKIP;
                     else
                        voice_next = 1'b1;
                  end
                  dial_pkg::CH_T: voice_next = 1'b0;
                  dial_pkg::CH_COMMA: pace.start = 1'b1;
                  dial_pkg::CH_SEMI, dial_pkg::CH_CR: begin
                     if (voice_reg) begin
                        vcall_next = 1'b1;
                        vline_next = (rx_char == dial_pkg::CH_SEMI);
                        ok_next    = !silence_replies;
                        state_next = dial_pkg::ST_CMD;
                     end else begin
                        dcall_next = 1'b1;
                        vline_next = 1'b0;
                        conn_next  = (rx_char == dial_pkg::CH_CR) && !silence_replies;
                        state_next = (rx_char == dial_pkg::CH_CR) ?
                                     dial_pkg::ST_DATA : dial_pkg::ST_CMD;
                     end
                  end
                  default: begin
                     if (is_dial_digit(rx_char)) begin
                        dv_next    = 1'b1;
                        digit_next = rx_char;
                        pulse_next = voice_reg;
                     end
                  end
               endcase
            end
         end
         dial_pkg::ST_SKIP: begin
            rx_ready = 1'b1;
            if (rx_valid && rx_char == dial_pkg::CH_CR) begin
               vline_next = 1'b0;
               state_next = dial_pkg::ST_CMD;
            end
         end
         dial_pkg::ST_DATA: begin
            rx_ready = 1'b1;
            if (rx_valid) begin
               if (rx_char != dial_pkg::CH_PLUS) begin
                  plus_next = 2'h0;
               end else if (plus_reg == dial_pkg::PLUS_LAST) begin
                  plus_next  = 2'h0;
                  state_next = dial_pkg::ST_CMD;
                  ok_next    = !silence_replies;
               end else begin
                  plus_next = plus_reg + 2'h1;
               end
            end
         end
         default: state_next = dial_pkg::ST_CMD;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg  <= dial_pkg::ST_CMD;
         voice_reg  <= 1'b0;
         waited_reg <= 1'b0;
         vline_reg  <= 1'b0;
         vcall_reg  <= 1'b0;
         dcall_reg  <= 1'b0;
         plus_reg   <= 2'h0;
         ok_reg     <= 1'b0;
         conn_reg   <= 1'b0;
         dv_reg     <= 1'b0;
         pulse_reg  <= 1'b0;
         digit_reg  <= 8'h00;
      end else begin
         state_reg  <= state_next;
         voice_reg  <= voice_next;
         waited_reg <= waited_next;
         vline_reg  <= vline_next;
         vcall_reg  <= vcall_next;
         dcall_reg  <= dcall_next;
         plus_reg   <= plus_next;
         ok_reg     <= ok_next;
         conn_reg   <= conn_next;
         dv_reg     <= dv_next;
         pulse_reg  <= pulse_next;
         digit_reg  <= digit_next;
      end
   end

   // speakerphone and indicators
   always_comb begin
      blink    = (pace.phase < dial_pkg::ON_QUARTERS);
      spk_next = !spk_inhibit &&
                 ((state_reg == dial_pkg::ST_DIAL && voice_reg && !spk_after_dial) ||
                  (spk_after_dial && vcall_reg && state_reg != dial_pkg::ST_DIAL));
      if (filt_reg[dial_pkg::SY_EXCH]) begin
         green_next = blink;
         red_next   = !blink;
      end else if (filt_reg[dial_pkg::SY_PHONE]) begin
         green_next = !blink;
         red_next   = blink;
      end else begin
         green_next = dcall_reg || vcall_reg;
         red_next   = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         spk_reg   <= 1'b0;
         green_reg <= 1'b0;
         red_reg   <= 1'b0;
      end else begin
         spk_reg   <= spk_next;
         green_reg <= green_next;
         red_reg   <= red_next;
      end
   end

   assign take             = rx_valid && rx_ready;
   assign dial_digit_valid = dv_reg;
   assign dial_digit       = digit_reg;
   assign dial_pulse       = pulse_reg;
   assign result_ok        = ok_reg;
   assign result_connect   = conn_reg;
   assign data_mode        = (state_reg == dial_pkg::ST_DATA);
   assign data_call        = dcall_reg;
   assign voice_call       = vcall_reg;
   assign speaker_on       = spk_reg;
   assign led_green        = green_reg;
   assign led_red          = red_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_DIGIT_MODE: assert property (take && state_reg == dial_pkg::ST_DIAL &&
      is_dial_digit(rx_char) |=> dial_digit_valid && dial_pulse == $past(voice_reg))
      else $error("digit dial type wrong");
   AST_DEFAULT_TONE: assert property (take && state_reg == dial_pkg::ST_CMD &&
      rx_char == dial_pkg::CH_D |=> !voice_reg)
      else $error("dial did not default to data");
   AST_SPEAKER: assert property (state_reg == dial_pkg::ST_DIAL && voice_reg &&
      !spk_inhibit && !spk_after_dial |=> speaker_on)
      else $error("speakerphone off while voice dialing");
   AST_VOICE_HELD: assert property (voice_call && !filt_reg[dial_pkg::SY_CLEAR]
      |=> voice_call)
      else $error("voice call cleared without telephone");
   AST_BLIND_FIRST: assert property (dial_digit_valid && dial_pulse |->
      $past(waited_reg) && !$past(pace.busy))
      else $error("voice digit sent before blind wait");
   AST_COMMA_PAUSE: assert property (take && state_reg == dial_pkg::ST_DIAL &&
      rx_char == dial_pkg::CH_COMMA && comma_pause_length != 8'h00 |=> pace.busy && !rx_ready)
      else $error("comma did not pause dialing");
   AST_SKIP_FILLER: assert property (take && state_reg == dial_pkg::ST_DIAL &&
      (rx_char == dial_pkg::CH_SPACE || rx_char == dial_pkg::CH_HYPHEN) |=> !dial_digit_valid)
      else $error("filler sent as digit");
   AST_VOICE_RETURN: assert property (take && state_reg == dial_pkg::ST_DIAL &&
      voice_reg && rx_char == dial_pkg::CH_CR |=> state_reg == dial_pkg::ST_CMD && voice_call)
      else $error("no return to command after voice dial");
   AST_ESCAPE: assert property (take && state_reg == dial_pkg::ST_DATA &&
      rx_char == dial_pkg::CH_PLUS && plus_reg == dial_pkg::PLUS_LAST
      |=> state_reg == dial_pkg::ST_CMD && result_ok == !$past(silence_replies))
      else $error("escape did not enter command mode");
   AST_HANG_UP: assert property (take && state_reg == dial_pkg::ST_CMD &&
      rx_char == dial_pkg::CH_H |=> !data_call)
      else $error("hang up left data call");
   AST_LED_OPPOSE: assert property (filt_reg[dial_pkg::SY_EXCH] |=>
      led_green == $past(blink) && led_red == !led_green)
      else $error("exchange loss pattern wrong");
   AST_SECOND_LINE_DROP: assert property (take && state_reg == dial_pkg::ST_CMD &&
      vline_reg && rx_char == dial_pkg::CH_D |=> state_reg == dial_pkg::ST_SKIP)
      else $error("second voice dial on line not dropped");

   COV_VOICE_DONE: cover property (take && state_reg == dial_pkg::ST_DIAL && voice_reg &&
      rx_char == dial_pkg::CH_CR);
   COV_ESCAPE: cover property (state_reg == dial_pkg::ST_DATA ##1 state_reg == dial_pkg::ST_CMD);
   COV_COMMA: cover property (take && rx_char == dial_pkg::CH_COMMA ##1 pace.busy);
endmodule

/* verif/host_term_model.sv */
// terminal model that offers command characters to the parser
// assumes the parser answers with a combinational ready on the same clock
`timescale 1ns/1ps
module host_term_model (
   input  wire logic       ref_clk,  // system clock
   input  wire logic       rx_ready, // character taken
   output logic            rx_valid, // character offered
   output logic [7:0]      rx_char   // command character
);
   // idle at time zero
   initial begin
      rx_valid = 1'b0;
      rx_char  = 8'h00;
   end
   // hold each character until taken, then show the inverse of the last one
   task automatic send_line(input string s, output bit ok);
      int n;
      ok = 1'b1;
      for (int i = 0; i < s.len(); i++) begin
         rx_valid <= 1'b1;
         rx_char  <= s[i];
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (rx_ready !== 1'b1 && n < 2000);
         if (n >= 2000) ok = 1'b0;
      end
      rx_valid <= 1'b0;
      rx_char  <= ~rx_char;
   endtask
endmodule

/* verif/test_voice_dial_command_parser.sv */
// self-checking bench for the dial command parser
// assumes a quarter second of 4 clocks, so one second is 16 clocks
`timescale 1ns/1ps
module test_voice_dial_command_parser;
   localparam logic [23:0] QC = 24'h4;
   logic       ref_clk, rst_n, rx_valid, rx_ready, exch_lost, phone_clear;
   logic       phone_lost, call_hold, silence, spk_inh, spk_after;
   logic [7:0] rx_char, blind_wait, comma_len, dial_digit;
   logic       digit_valid, dial_pulse, res_ok, res_conn, data_mode, data_call;
   logic       voice_call, speaker_on, led_green, led_red;
   int         fail_count, compares, cyc, ok_n, conn_n, g, mism, spk_n;
   int         t_d[$];
   string      digits;
   bit         ok;

   host_term_model host_term_model_i (.ref_clk(ref_clk), .rx_ready(rx_ready),
      .rx_valid(rx_valid), .rx_char(rx_char));
   voice_dial_command_parser #(.QUARTER_CYCLES(QC)) voice_dial_command_parser_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_char(rx_char),
      .rx_ready(rx_ready), .blind_dial_wait(blind_wait), .comma_pause_length(comma_len),
      .silence_replies(silence), .spk_inhibit(spk_inh), .spk_after_dial(spk_after),
      .exch_lost_pin(exch_lost), .phone_lost_pin(phone_lost), .phone_clear_pin(phone_clear),
      .call_hold_pin(call_hold), .dial_digit_valid(digit_valid), .dial_digit(dial_digit),
      .dial_pulse(dial_pulse), .result_ok(res_ok), .result_connect(res_conn),
      .data_mode(data_mode), .data_call(data_call), .voice_call(voice_call),
      .speaker_on(speaker_on), .led_green(led_green), .led_red(led_red));

   // 40 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // log digits with their dialing type, and count result pulses
   always @(posedge ref_clk) begin
      cyc++;
      if (digit_valid === 1'b1) begin
         digits = $sformatf("%s%c%s", digits, dial_digit, dial_pulse ? "p" : "t");
         t_d.push_back(cyc);
         if (dial_pulse === 1'b1 && speaker_on === 1'b1) spk_n++;
      end
      if (res_ok === 1'b1) ok_n++;
      if (res_conn === 1'b1) conn_n++;
   end

   task automatic wrap_up;
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask
   task automatic chk_num(input int got, input int lo, input int hi, input string what);
      compares++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("[ERR] %0t %s got %0d", $time, what, got);
      end
   endtask
   task automatic chk_str(input string got, input string exp);
      compares++;
      if (got != exp) begin
         fail_count++;
         $display("[ERR] %0t digits %s", $time, got);
      end
   endtask
   task automatic send(input string s);
      host_term_model_i.send_line(s, ok);
      if (!ok) begin
         fail_count++;
         $display("[ERR] %0t character not taken", $time);
         wrap_up();
      end
      repeat (4) @(posedge ref_clk);
   endtask
   // set the link loss pins, let the filter settle, then count indicator states
   task automatic led_watch(input logic exch, input logic phone);
      exch_lost  <= exch;
      phone_lost <= phone;
      repeat (8) @(posedge ref_clk);
      {g, mism} = 0;
      repeat (64) begin
         @(posedge ref_clk);
         g += (led_green === 1'b1);
         mism += (led_red !== ~led_green);
      end
   endtask

   // main sequence
   initial begin
      {rst_n, exch_lost, phone_clear, phone_lost, call_hold} = 5'h00;
      {silence, spk_inh, spk_after} = 3'h0;
      blind_wait = 8'h01;
      comma_len  = 8'h01;
      digits = "";
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk_bit(data_mode, 1'b0, "mode after reset");
      send("D1-2 3\r");
      chk_str(digits, "1t2t3t");
      chk_bit(data_mode, 1'b1, "data mode");
      send("+++");
      chk_bit(data_mode, 1'b0, "escape");
      chk_num(ok_n, 1, 1, "escape ok");
      send("O\r");
      chk_bit(data_mode, 1'b1, "resume");
      chk_num(conn_n, 2, 2, "resume connect");
      send("+++H\r");
      chk_bit(data_call, 1'b0, "hang up");
      chk_num(ok_n, 3, 3, "hang up ok");
      send("DT8;DP9,,1;DP5\r");
      chk_str(digits, "1t2t3t8t9p1p");
      chk_num(t_d[4] - t_d[3], 16, 26, "blind wait");
      chk_num(t_d[5] - t_d[4], 32, 40, "comma pauses");
      chk_bit(voice_call, 1'b1, "voice call");
      chk_bit(data_mode, 1'b0, "back to command");
      chk_num(spk_n, 2, 2, "speaker while dialing");
      send("DP7\r");
      chk_num(t_d.size(), 6, 6, "second voice dial");
      call_hold <= 1'b1;
      spk_after <= 1'b1;
      repeat (4) @(posedge ref_clk);
      send("DP7\r");
      chk_str(digits, "1t2t3t8t9p1p7p");
      chk_num(spk_n, 2, 2, "speaker held to after dial");
      chk_bit(speaker_on, 1'b1, "speaker after dial");
      call_hold <= 1'b0;
      spk_inh   <= 1'b1;
      silence   <= 1'b1;
      send("H\r");
      chk_bit(voice_call, 1'b1, "host cannot clear");
      chk_bit(speaker_on, 1'b0, "speaker inhibited");
      chk_num(ok_n, 5, 5, "replies silenced");
      phone_clear <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk_bit(voice_call, 1'b0, "telephone clears");
      phone_clear <= 1'b0;
      led_watch(1'b1, 1'b0);
      chk_num(g, 48, 48, "green on time");
      chk_num(mism, 0, 0, "red inverse");
      led_watch(1'b0, 1'b1);
      chk_num(g, 16, 16, "green on phone loss");
      chk_num(mism, 0, 0, "red inverse on phone loss");
      wrap_up();
   end
endmodule
